// file: rtl/i2cx_regmap.sv
`timescale 1ns/1ps
module i2cx_regmap (
  input  wire logic             core_clk_in,   // Core clock, 200 MHz.
  input  wire logic             nrst_in,       // Async reset, active low.
  input  wire logic             clk_en_in,     // Freezes all state when low.
  input  wire logic             scl_in,        // Bus clock pin.
  input  wire logic             sda_in,        // Bus data pin level.
  output logic                  sda_out,       // Data pin drive value.
  output logic                  sda_oe_out,    // Data pin pulled low.
  input  wire logic             addr_strap_in, // Address strap pin.
  input  wire logic             hw_rst_n_in,   // Reset pin, active low.
  input  wire logic [7:0]       port_in,       // Port pin levels.
  output logic [7:0]            port_out,      // Port pin drive values.
  output logic [7:0]            port_oe_out,   // Port pin drive enables.
  input  wire logic [7:0]       event_src_in,  // Event sources, core clock.
  output i2cx_pkg::i2cx_cfg_s   cfg_out        // Feature settings.
);

  // ==========================================================
  // Pin synchronisers
  logic [11:0] sync_raw;
  logic [11:0] sync1_q;
  logic [11:0] sync2_q;
  logic        scl_p_q;
  logic        sda_p_q;

  assign sync_raw = {hw_rst_n_in, addr_strap_in, sda_in, scl_in, port_in};

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_q <= i2cx_pkg::SYNC_RST;
      sync2_q <= i2cx_pkg::SYNC_RST;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (clk_en_in) begin
      sync1_q <= sync_raw;
      sync2_q <= sync1_q;
      scl_p_q <= sync2_q[8];
      sda_p_q <= sync2_q[9];
    end
  end

  wire       scl_s   = sync2_q[8];
  wire       sda_s   = sync2_q[9];
  wire       strap_s = sync2_q[10];
  wire       hwrn_s  = sync2_q[11];
  wire [7:0] pins_s  = sync2_q[7:0];

  // ==========================================================
  // Bus conditions
  wire scl_hi = scl_s & scl_p_q;
  wire rise   = clk_en_in & scl_s & ~scl_p_q;
  wire fall   = clk_en_in & ~scl_s & scl_p_q;
  wire start  = clk_en_in & scl_hi & sda_p_q & ~sda_s;
  wire stop   = clk_en_in & scl_hi & ~sda_p_q & sda_s;

  localparam int         NRWM = i2cx_pkg::NRW - 1;
  i2cx_pkg::i2cx_state_e st_q;
  i2cx_pkg::i2cx_state_e nxt_q;
  i2cx_pkg::i2cx_state_e nxt_now;
  logic [3:0]            cnt_q;
  logic [7:0]            sh_q;
  logic [7:0]            tx_q;
  logic                  ack_q;
  logic                  drv_q;
  logic                  nack_q;
  logic                  gc_arm_q;
  logic                  ack_now;
  logic [7:0]            ptr_q;
  logic [NRWM:0][7:0]    rw_q;
  logic [7:0]            rdata;

  // A soft reset only fires on the stop that closes a clean call.
  wire soft_rst = stop & gc_arm_q;
  wire clr      = clk_en_in & (~hwrn_s | soft_rst);

  wire [6:0] my_addr  = strap_s ? i2cx_pkg::ADDR_HIGH
                                : i2cx_pkg::ADDR_LOW;
  wire       addr_hit = (sh_q[7:1] == my_addr);
  wire       gc_hit   = (sh_q == i2cx_pkg::GC_ADDR);
  wire       rx_st    = (st_q == i2cx_pkg::ST_ADDR)
                      | (st_q == i2cx_pkg::ST_CMD)
                      | (st_q == i2cx_pkg::ST_WDATA)
                      | (st_q == i2cx_pkg::ST_GC);
  wire       byte_end = fall & ~ack_q & rx_st
                      & (cnt_q == i2cx_pkg::BIT_LAST);
  wire       ack_end  = fall & ack_q;
  wire       wr       = byte_end & (st_q == i2cx_pkg::ST_WDATA);

  // ==========================================================
  // Decision on each completed byte
  always_comb begin
    ack_now = 1'b0;
    nxt_now = i2cx_pkg::ST_IGNORE;
    case (st_q)
      i2cx_pkg::ST_ADDR: begin
        if (addr_hit) begin
          ack_now = 1'b1;
          nxt_now = sh_q[0] ? i2cx_pkg::ST_RDATA
                            : i2cx_pkg::ST_CMD;
        end else if (gc_hit) begin
          ack_now = 1'b1;
          nxt_now = i2cx_pkg::ST_GC;
        end
      end
      i2cx_pkg::ST_CMD, i2cx_pkg::ST_WDATA: begin
        ack_now = 1'b1;
        nxt_now = i2cx_pkg::ST_WDATA;
      end
      i2cx_pkg::ST_GC: begin
        ack_now = (sh_q == i2cx_pkg::GC_RESET) & ~gc_arm_q;
        nxt_now = i2cx_pkg::ST_GC;
      end
      default: begin
        ack_now = 1'b0;
        nxt_now = i2cx_pkg::ST_IGNORE;
      end
    endcase
  end

  // ==========================================================
  // Bit engine
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q     <= i2cx_pkg::ST_IDLE;
      nxt_q    <= i2cx_pkg::ST_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      ack_q    <= 1'b0;
      drv_q    <= 1'b0;
      nack_q   <= 1'b0;
      gc_arm_q <= 1'b0;
    end else if (clr | stop | start) begin
      st_q     <= start ? i2cx_pkg::ST_ADDR : i2cx_pkg::ST_IDLE;
      cnt_q    <= 4'h0;
      ack_q    <= 1'b0;
      drv_q    <= 1'b0;
      gc_arm_q <= 1'b0;
    end else if (rise) begin
      if (rx_st & ~cnt_q[3]) begin
        sh_q  <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
      end else if (st_q == i2cx_pkg::ST_RDATA) begin
        if (~cnt_q[3]) begin
          cnt_q <= cnt_q + 4'h1;
        end else if (cnt_q == i2cx_pkg::BIT_LAST) begin
          nack_q <= sda_s;
          cnt_q  <= i2cx_pkg::ACK_DONE;
        end
      end
    end else if (fall) begin
      if (byte_end) begin
        ack_q <= ack_now;
        drv_q <= ack_now;
        nxt_q <= nxt_now;
        if (!ack_now) begin
          st_q <= i2cx_pkg::ST_IGNORE;
        end
        if (st_q == i2cx_pkg::ST_GC) begin
          gc_arm_q <= ack_now;
        end
      end else if (ack_q) begin
        ack_q <= 1'b0;
        cnt_q <= 4'h0;
        st_q  <= nxt_q;
        tx_q  <= rdata;
        drv_q <= (nxt_q == i2cx_pkg::ST_RDATA) & ~rdata[7];
      end else if (st_q == i2cx_pkg::ST_RDATA) begin
        if (cnt_q == i2cx_pkg::ACK_DONE) begin
          if (nack_q) begin
            st_q  <= i2cx_pkg::ST_IGNORE;
            drv_q <= 1'b0;
          end else begin
            tx_q  <= rdata;
            drv_q <= ~rdata[7];
            cnt_q <= 4'h0;
          end
        end else if (cnt_q == i2cx_pkg::BIT_LAST) begin
          drv_q <= 1'b0;
        end else begin
          drv_q <= ~tx_q[6];
          tx_q  <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================
  // Register pointer
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ptr_q <= i2cx_pkg::PTR_RST;
    end else if (clr) begin
      ptr_q <= i2cx_pkg::PTR_RST;
    end else if (byte_end & (st_q == i2cx_pkg::ST_CMD)) begin
      ptr_q <= sh_q;
    end
  end

  // ==========================================================
  // Read/write registers and read selection
  logic [NRWM:0]      hit;
  logic [NRWM:0][7:0] rd_part;
  logic [7:0]         rd_rw;

  genvar gi;
  generate
    for (gi = 0; gi < i2cx_pkg::NRW; gi++) begin : g_rw
      assign hit[gi]     = (ptr_q == i2cx_pkg::RW_OFS[gi]);
      assign rd_part[gi] = hit[gi] ? rw_q[gi] : 8'h00;
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          rw_q[gi] <= i2cx_pkg::RW_RST[gi];
        end else if (clr) begin
          rw_q[gi] <= i2cx_pkg::RW_RST[gi];
        end else if (wr & hit[gi]) begin
          rw_q[gi] <= sh_q;
        end
      end
    end
  endgenerate

  always_comb begin
    rd_rw = 8'h00;
    for (int i = 0; i < i2cx_pkg::NRW; i++) begin
      rd_rw = rd_rw | rd_part[i];
    end
  end

  wire [7:0] pin_view = pins_s ^ rw_q[i2cx_pkg::IX_INV];
  wire [7:0] stat_view = event_src_in & ~rw_q[i2cx_pkg::IX_MASK];

  // The input register has no storage, so a write to it finds no target.
  assign rdata = (ptr_q == i2cx_pkg::REG_IN)   ? pin_view :
                 (ptr_q == i2cx_pkg::REG_STAT) ? stat_view :
                 rd_rw;

  // ==========================================================
  // Pins and settings
  wire [7:0] outv = rw_q[i2cx_pkg::IX_OUT];
  wire [7:0] odm  = rw_q[i2cx_pkg::IX_STG][0] ? ~outv : 8'hff;

  assign sda_out     = 1'b0;
  assign sda_oe_out  = drv_q;
  assign port_out    = outv;
  assign port_oe_out = ~rw_q[i2cx_pkg::IX_DIR] & odm;

  assign cfg_out.drive_low  = rw_q[i2cx_pkg::IX_DRL];
  assign cfg_out.drive_high = rw_q[i2cx_pkg::IX_DRH];
  assign cfg_out.hold       = rw_q[i2cx_pkg::IX_HOLD];
  assign cfg_out.res_en     = rw_q[i2cx_pkg::IX_REN];
  assign cfg_out.res_dir    = rw_q[i2cx_pkg::IX_RDIR];
  assign cfg_out.mask       = rw_q[i2cx_pkg::IX_MASK];
  assign cfg_out.stage      = rw_q[i2cx_pkg::IX_STG];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_addr_byte;
    byte_end && st_q == i2cx_pkg::ST_ADDR && addr_hit && !clr;
  endsequence

  sequence s_rd_load;
    ack_end && !clr && nxt_q == i2cx_pkg::ST_RDATA;
  endsequence

  property p_addr_ack;
    s_addr_byte |=> drv_q && ack_q;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_dir;
    s_addr_byte |=> nxt_q == ($past(sh_q[0]) ? i2cx_pkg::ST_RDATA
                                             : i2cx_pkg::ST_CMD);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction bit misread");

  property p_cmd;
    byte_end && st_q == i2cx_pkg::ST_CMD && !clr |=> ptr_q == $past(sh_q);
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command byte not captured");

  property p_ptr_read;
    st_q == i2cx_pkg::ST_RDATA && !clr |=> ptr_q == $past(ptr_q);
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("pointer moved during read");

  property p_ptr_clr;
    clr |=> ptr_q == i2cx_pkg::PTR_RST;
  endproperty
  a_ptr_clr: assert property (p_ptr_clr)
    else $error("pointer not cleared");

  property p_in_ro;
    wr && ptr_q == i2cx_pkg::REG_IN && !clr |=> $stable(rw_q);
  endproperty
  a_in_ro: assert property (p_in_ro)
    else $error("input register write changed state");

  property p_unmapped;
    wr && hit == '0 && !clr |=> $stable(rw_q) && $stable(ptr_q);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unlisted code write changed state");

  property p_wr_out;
    wr && hit[i2cx_pkg::IX_OUT] && !clr |=>
      port_out == $past(sh_q);
  endproperty
  a_wr_out: assert property (p_wr_out)
    else $error("data byte not stored");

  property p_rd_out;
    (s_rd_load and ptr_q == i2cx_pkg::RW_OFS[i2cx_pkg::IX_OUT]) |=>
      tx_q == $past(outv);
  endproperty
  a_rd_out: assert property (p_rd_out)
    else $error("output register read wrong");

  property p_rd_in;
    (s_rd_load and ptr_q == i2cx_pkg::REG_IN) |=> tx_q == $past(pin_view);
  endproperty
  a_rd_in: assert property (p_rd_in)
    else $error("input register read wrong");

  property p_dir_in;
    rw_q[i2cx_pkg::IX_DIR] == 8'hff |-> port_oe_out == 8'h00;
  endproperty
  a_dir_in: assert property (p_dir_in)
    else $error("input pin driven");

endmodule

// file: inc/i2cx_pkg.sv
package i2cx_pkg;

  // ==========================================================
  // Bus addresses and command codes
  localparam logic [6:0] ADDR_LOW  = 7'h20;
  localparam logic [6:0] ADDR_HIGH = 7'h21;
  localparam logic [7:0] GC_ADDR   = 8'h00;
  localparam logic [7:0] GC_RESET  = 8'h06;
  localparam logic [7:0] REG_IN    = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h46;
  localparam logic [7:0] PTR_RST   = 8'h00;

  // ==========================================================
  // Read/write registers: index 0 output, 1 invert, 2 direction,
  // 3..4 drive strength, 5 hold, 6 resistor enable, 7 resistor
  // direction, 8 event mask, 9 output stage type.
  localparam int NRW     = 10;
  localparam int IX_OUT  = 0;
  localparam int IX_INV  = 1;
  localparam int IX_DIR  = 2;
  localparam int IX_DRL  = 3;
  localparam int IX_DRH  = 4;
  localparam int IX_HOLD = 5;
  localparam int IX_REN  = 6;
  localparam int IX_RDIR = 7;
  localparam int IX_MASK = 8;
  localparam int IX_STG  = 9;
  localparam logic [NRW-1:0][7:0] RW_OFS = {8'h4f, 8'h45, 8'h44, 8'h43,
    8'h42, 8'h41, 8'h40, 8'h03, 8'h02, 8'h01};
  localparam logic [NRW-1:0][7:0] RW_RST = {8'h00, 8'hff, 8'hff, 8'h00,
    8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff};

  // ==========================================================
  // Bit counting and synchroniser reset levels
  localparam logic [3:0]  BIT_LAST = 4'h8;
  localparam logic [3:0]  ACK_DONE = 4'h9;
  localparam logic [11:0] SYNC_RST = 12'hb00;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_GC, ST_IGNORE
  } i2cx_state_e;

  typedef struct packed {
    logic [7:0] drive_low;
    logic [7:0] drive_high;
    logic [7:0] hold;
    logic [7:0] res_en;
    logic [7:0] res_dir;
    logic [7:0] mask;
    logic [7:0] stage;
  } i2cx_cfg_s;

endpackage

// file: bench/i2cx_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================================
// Bus controller model
// Pins move one step after a core clock edge, so bus timing is
// always a whole number of core cycles: 16 cycles per SCL period.
module i2cx_ctrl_model (
  input  wire logic clk_in,     // Core clock for pacing.
  input  wire logic sda_in,     // Resolved data line.
  output logic      scl_out,    // Bus clock, high when idle.
  output logic      sda_oe_out  // High pulls the data line low.
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic start();
    sda_oe_out = 1'b0;
    tk(4);
    scl_out = 1'b1;
    tk(4);
    sda_oe_out = 1'b1;
    tk(4);
    scl_out = 1'b0;
    tk(4);
  endtask
  task automatic put(input logic b);
    sda_oe_out = ~b;
    tk(4);
    scl_out = 1'b1;
    tk(8);
    scl_out = 1'b0;
    tk(4);
  endtask
  task automatic get(output logic b);
    sda_oe_out = 1'b0;
    tk(4);
    scl_out = 1'b1;
    tk(4);
    b = sda_in;
    tk(4);
    scl_out = 1'b0;
    tk(4);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    ack = ~a;
  endtask
  task automatic rbyte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(last);
  endtask
  task automatic stop();
    sda_oe_out = 1'b1;
    tk(4);
    scl_out = 1'b1;
    tk(4);
    sda_oe_out = 1'b0;
    tk(8);
  endtask
endmodule

// file: bench/tb_i2c_expander_register_map.sv
`timescale 1ns/1ps
module tb_i2c_expander_register_map;
  logic                core_clk_in;
  logic                nrst_in;
  logic                clk_en_in;
  logic                addr_strap_in;
  logic                hw_rst_n_in;
  logic [7:0]          port_in;
  logic [7:0]          event_src_in;
  logic                sda_out;
  logic                sda_oe_out;
  logic [7:0]          port_out;
  logic [7:0]          port_oe_out;
  i2cx_pkg::i2cx_cfg_s cfg_out;
  logic                scl;
  logic                m_oe;
  logic [6:0]          dev;
  logic [7:0]          cd [10];
  logic [7:0]          rv [10];
  int                  num_errors;
  int                  n_tests;
  wire logic           sda;

  // The data line has a pull-up, so it reads high when nobody pulls.
  assign sda = ~(m_oe | sda_oe_out);
  assign cd = '{8'h01, 8'h02, 8'h03, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
    8'h45, 8'h4f};
  assign rv = '{8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff,
    8'hff, 8'h00};

  i2cx_regmap dut_u (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .addr_strap_in(addr_strap_in),
    .hw_rst_n_in(hw_rst_n_in), .port_in(port_in), .port_out(port_out),
    .port_oe_out(port_oe_out), .event_src_in(event_src_in),
    .cfg_out(cfg_out));
  i2cx_ctrl_model mdl_u (.clk_in(core_clk_in), .sda_in(sda),
    .scl_out(scl), .sda_oe_out(m_oe));

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // ==========================================================
  // Shared checking and bus transfers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] code, input logic [7:0] d,
                    input int n);
    logic a;
    mdl_u.start();
    mdl_u.wbyte({dev, 1'b0}, a);
    chk({7'h00, a}, 8'h01);
    mdl_u.wbyte(code, a);
    chk({7'h00, a}, 8'h01);
    for (int k = 0; k < n; k++) begin
      mdl_u.wbyte(d + 8'(k), a);
      chk({7'h00, a}, 8'h01);
    end
    mdl_u.stop();
  endtask
  task automatic rd(output logic [7:0] d);
    logic a;
    mdl_u.start();
    mdl_u.wbyte({dev, 1'b1}, a);
    chk({7'h00, a}, 8'h01);
    mdl_u.rbyte(d, 1'b1);
    mdl_u.stop();
  endtask
  task automatic rdc(input logic [7:0] code, input logic [7:0] exp);
    logic [7:0] d;
    wr(code, 8'h00, 0);
    rd(d);
    chk(d, exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    rd(d);
    chk(d, 8'h3c);
    for (int i = 0; i < 10; i++) rdc(cd[i], rv[i]);
    rdc(8'h46, 8'h00);
    rdc(8'h05, 8'h00);
    rdc(8'h47, 8'h00);
    chk(port_out, 8'hff);
    chk(port_oe_out, 8'h00);
    chk({7'h00, sda_out}, 8'h00);
    $display("test reset values done");
  endtask
  task automatic t_rw();
    for (int i = 0; i < 10; i++) wr(cd[i], {4'(i), 4'ha}, 1);
    wr(8'h00, 8'h00, 1);
    wr(8'h46, 8'h00, 1);
    wr(8'h4e, 8'h00, 1);
    for (int i = 0; i < 10; i++) rdc(cd[i], {4'(i), 4'ha});
    rdc(8'h00, 8'h3c ^ 8'h1a);
    rdc(8'h46, 8'h75);
    chk(port_out, 8'h0a);
    chk(port_oe_out, 8'hd5);
    chk(cfg_out.drive_low, 8'h3a);
    chk(cfg_out.drive_high, 8'h4a);
    chk(cfg_out.stage, 8'h9a);
    chk(cfg_out.hold, 8'h5a);
    chk(cfg_out.res_en, 8'h6a);
    chk(cfg_out.res_dir, 8'h7a);
    chk(cfg_out.mask, 8'h8a);
    $display("test read write done");
  endtask
  task automatic t_ptr();
    logic [7:0] d;
    wr(8'h02, 8'h70, 2);
    rd(d);
    chk(d, 8'h71);
    rd(d);
    chk(d, 8'h71);
    rdc(8'h03, 8'h2a);
    $display("test pointer done");
  endtask
  task automatic t_addr();
    logic a;
    addr_strap_in = 1'b1;
    mdl_u.tk(8);
    mdl_u.start();
    mdl_u.wbyte({7'h20, 1'b0}, a);
    chk({7'h00, a}, 8'h00);
    mdl_u.stop();
    dev = 7'h21;
    rdc(8'h01, 8'h0a);
    $display("test address done");
  endtask
  task automatic t_resets();
    logic [7:0] d;
    logic       a;
    // A reset pulse while the clock enable is low must be missed.
    clk_en_in = 1'b0;
    hw_rst_n_in = 1'b0;
    mdl_u.tk(4);
    hw_rst_n_in = 1'b1;
    mdl_u.tk(2);
    clk_en_in = 1'b1;
    mdl_u.tk(4);
    chk(port_oe_out, 8'hd5);
    rd(d);
    chk(d, 8'h0a);
    hw_rst_n_in = 1'b0;
    mdl_u.tk(4);
    hw_rst_n_in = 1'b1;
    mdl_u.tk(4);
    rd(d);
    chk(d, 8'h3c);
    chk(port_out, 8'hff);
    wr(8'h03, 8'h00, 1);
    mdl_u.start();
    mdl_u.wbyte(8'h00, a);
    mdl_u.wbyte(8'h06, a);
    chk({7'h00, a}, 8'h01);
    mdl_u.stop();
    rd(d);
    chk(d, 8'h3c);
    rdc(8'h03, 8'hff);
    $display("test resets done");
  endtask

  initial begin
    #400us;
    num_errors++;
    report_and_stop();
  end

  initial begin
    num_errors = 0;
    n_tests = 0;
    nrst_in = 1'b0;
    clk_en_in = 1'b1;
    addr_strap_in = 1'b0;
    hw_rst_n_in = 1'b1;
    port_in = 8'h3c;
    event_src_in = 8'hff;
    dev = 7'h20;
    mdl_u.tk(4);
    nrst_in = 1'b1;
    mdl_u.tk(4);
    t_reset();
    t_rw();
    t_ptr();
    t_addr();
    t_resets();
    report_and_stop();
  end
endmodule
